/* inc/gtacl_pkg.sv */
// Constants for the gain trim and ac lead-off amplitude register bank
package gtacl_pkg;
  localparam int CMD_W = 32;
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 24;
  localparam logic [7:0] ADDR_OPERATING_STATE = 8'h1F;
  localparam logic [7:0] ADDR_GAIN_TRIM_LA = 8'h21;
  localparam logic [7:0] ADDR_GAIN_TRIM_LL = 8'h22;
  localparam logic [7:0] ADDR_GAIN_TRIM_RA = 8'h23;
  localparam logic [7:0] ADDR_TONE_AMP_LA = 8'h31;
  localparam logic [7:0] ADDR_TONE_AMP_LL = 8'h32;
  localparam logic [7:0] ADDR_TONE_AMP_RA = 8'h33;
  localparam int USER_TRIM_SELECT_BIT = 23;
  localparam int TRIM_W = 12;
  localparam int TRIM_SHIFT = 17;
  localparam int AMP_W = 16;
  localparam int NUM_CH = 3;
  localparam int NUM_FACTORY_GAINS = 3;
  localparam logic [1:0] GAIN_NO_FACTORY = 2'h3;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 12'h000;
  localparam logic USER_TRIM_SELECT_RESET = 1'b0;
  localparam logic [AMP_W-1:0] AMP_RESET = 16'h0000;
  localparam int CLK_HZ = 50000000;
  localparam int TONE_HZ = 2000;
  localparam int UPDATE_HZ = 8;
  localparam int CUTOFF_HZ = 2;
  localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
  localparam int AVG_SHIFT = 10;
endpackage : gtacl_pkg

/* core/gtacl_tone_avg.sv */
// Rectify-and-average filter for one electrode's band-pass tone samples
`timescale 1ns/1ps
module gtacl_tone_avg #(
  parameter int SHIFT = gtacl_pkg::AVG_SHIFT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic signed [gtacl_pkg::AMP_W-1:0] sample,
  input wire logic update_tick,
  output logic [gtacl_pkg::AMP_W-1:0] code_q
);
  localparam int AW = gtacl_pkg::AMP_W + SHIFT + 1;
  logic [AW-1:0] acc_q;
  logic [gtacl_pkg::AMP_W:0] rect;
  logic [AW-1:0] acc_d;

  // Full-wave rectifier; magnitude of -32768 needs the extra bit
  always_comb begin
    rect = sample[gtacl_pkg::AMP_W-1] ? (~{1'b1, sample} + 17'h00001) : {1'b0, sample};
    acc_d = acc_q - (acc_q >> SHIFT) + AW'(rect);
  end

  // One-pole average; SHIFT sets the low cutoff against the sample rate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else if (!enable) begin
      acc_q <= '0;
    end else if (sample_valid) begin
      acc_q <= acc_d;
    end
  end

  // Result only moves on the slow tick so host reads are stable between updates
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      code_q <= gtacl_pkg::AMP_RESET;
    end else if (update_tick) begin
      code_q <= acc_q[AW-1] ? 16'hFFFF : acc_q[AW-2 -: gtacl_pkg::AMP_W];
    end
  end
endmodule : gtacl_tone_avg

/* core/gtacl_regs.sv */
// Gain trim registers, trim datapath and ac lead-off amplitude registers
`timescale 1ns/1ps
module gtacl_regs #(
  parameter int CH_W = 24,
  parameter int UPDATE_CYCLES = gtacl_pkg::UPDATE_CYCLES,
  parameter int AVG_SHIFT = gtacl_pkg::AVG_SHIFT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [gtacl_pkg::CMD_W-1:0] cmd_word,
  output logic rsp_valid,
  output logic [gtacl_pkg::CMD_W-1:0] rsp_word,
  input wire logic [1:0] gain_setting,
  input wire logic [3*gtacl_pkg::TRIM_W-1:0] factory_trim_la,
  input wire logic [3*gtacl_pkg::TRIM_W-1:0] factory_trim_ll,
  input wire logic [3*gtacl_pkg::TRIM_W-1:0] factory_trim_ra,
  input wire logic ch_valid,
  input wire logic signed [CH_W-1:0] ch_data_la,
  input wire logic signed [CH_W-1:0] ch_data_ll,
  input wire logic signed [CH_W-1:0] ch_data_ra,
  output logic ch_out_valid,
  output logic signed [CH_W-1:0] ch_out_la,
  output logic signed [CH_W-1:0] ch_out_ll,
  output logic signed [CH_W-1:0] ch_out_ra,
  input wire logic acloff_enable,
  input wire logic tone_valid,
  input wire logic signed [gtacl_pkg::AMP_W-1:0] tone_sample_la,
  input wire logic signed [gtacl_pkg::AMP_W-1:0] tone_sample_ll,
  input wire logic signed [gtacl_pkg::AMP_W-1:0] tone_sample_ra
);
  localparam int TW = gtacl_pkg::TRIM_W;
  localparam int NC = gtacl_pkg::NUM_CH;
  localparam int CW = $clog2(UPDATE_CYCLES);

  logic user_trim_select_q [NC];
  logic [TW-1:0] gain_trim_value_q [NC];
  logic [3*TW-1:0] factory [NC];
  logic signed [CH_W-1:0] ch_in [NC];
  logic signed [gtacl_pkg::AMP_W-1:0] tone_in [NC];
  logic [gtacl_pkg::AMP_W-1:0] tone_amplitude_code [NC];
  logic [CW-1:0] tick_cnt_q;
  logic update_tick_q;
  logic [7:0] cmd_addr;
  logic [TW-1:0] eff_trim [NC];

  assign factory[0] = factory_trim_la;
  assign factory[1] = factory_trim_ll;
  assign factory[2] = factory_trim_ra;
  assign ch_in[0] = ch_data_la;
  assign ch_in[1] = ch_data_ll;
  assign ch_in[2] = ch_data_ra;
  assign tone_in[0] = tone_sample_la;
  assign tone_in[1] = tone_sample_ll;
  assign tone_in[2] = tone_sample_ra;
  assign cmd_addr = cmd_word[gtacl_pkg::ADDR_MSB:gtacl_pkg::ADDR_LSB];

  // Trim in effect for one channel at the present gain setting
  function automatic logic [TW-1:0] trim_in_effect(
    input logic sel,
    input logic [TW-1:0] user,
    input logic [3*TW-1:0] fact,
    input logic [1:0] gain
  );
    logic [TW-1:0] result;
    result = user;
    if (!sel) begin
      // No factory value exists at the top gain, so it falls back to unity
      if (gain == gtacl_pkg::GAIN_NO_FACTORY) begin
        result = '0;
      end else begin
        result = fact[gain*TW +: TW];
      end
    end
    return result;
  endfunction : trim_in_effect

  // data * (1 + trim * 2^-17), arithmetic shift truncates toward minus infinity
  function automatic logic signed [CH_W-1:0] apply_trim(
    input logic signed [CH_W-1:0] data,
    input logic [TW-1:0] trim
  );
    logic signed [CH_W+TW-1:0] prod;
    logic signed [CH_W+TW-1:0] shifted;
    prod = data * $signed(trim);
    shifted = prod >>> gtacl_pkg::TRIM_SHIFT;
    return data + shifted[CH_W-1:0];
  endfunction : apply_trim

  // Map a command address to a channel index of a three-register group
  function automatic logic [1:0] chan_of(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    return diff[1:0];
  endfunction : chan_of

  always_comb begin
    for (int i = 0; i < NC; i++) begin
      eff_trim[i] = trim_in_effect(user_trim_select_q[i], gain_trim_value_q[i],
                                   factory[i], gain_setting);
    end
  end

  // Register writes; reserved bits 22:12 are dropped whatever the host sends
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NC; i++) begin
        user_trim_select_q[i] <= gtacl_pkg::USER_TRIM_SELECT_RESET;
        gain_trim_value_q[i] <= gtacl_pkg::TRIM_RESET;
      end
    end else if (cmd_valid && cmd_write && cmd_addr >= gtacl_pkg::ADDR_GAIN_TRIM_LA
                 && cmd_addr <= gtacl_pkg::ADDR_GAIN_TRIM_RA) begin
      user_trim_select_q[chan_of(cmd_addr, gtacl_pkg::ADDR_GAIN_TRIM_LA)] <=
        cmd_word[gtacl_pkg::USER_TRIM_SELECT_BIT];
      gain_trim_value_q[chan_of(cmd_addr, gtacl_pkg::ADDR_GAIN_TRIM_LA)] <=
        cmd_word[TW-1:0];
    end
  end

  // Reads answer only to an explicit read command, one cycle later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_word <= '0;
    end else begin
      rsp_valid <= cmd_valid && !cmd_write;
      if (cmd_valid && !cmd_write) begin
        rsp_word <= {cmd_addr, 24'h000000};
        if (cmd_addr >= gtacl_pkg::ADDR_GAIN_TRIM_LA
            && cmd_addr <= gtacl_pkg::ADDR_GAIN_TRIM_RA) begin
          rsp_word[gtacl_pkg::USER_TRIM_SELECT_BIT] <=
            user_trim_select_q[chan_of(cmd_addr, gtacl_pkg::ADDR_GAIN_TRIM_LA)];
          rsp_word[TW-1:0] <= eff_trim[chan_of(cmd_addr, gtacl_pkg::ADDR_GAIN_TRIM_LA)];
        end else if (cmd_addr >= gtacl_pkg::ADDR_TONE_AMP_LA
                     && cmd_addr <= gtacl_pkg::ADDR_TONE_AMP_RA) begin
          rsp_word[gtacl_pkg::AMP_W-1:0] <=
            tone_amplitude_code[chan_of(cmd_addr, gtacl_pkg::ADDR_TONE_AMP_LA)];
        end
      end
    end
  end

  // Trim datapath, one cycle of latency
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ch_out_valid <= 1'b0;
      ch_out_la <= '0;
      ch_out_ll <= '0;
      ch_out_ra <= '0;
    end else begin
      ch_out_valid <= ch_valid;
      if (ch_valid) begin
        ch_out_la <= apply_trim(ch_in[0], eff_trim[0]);
        ch_out_ll <= apply_trim(ch_in[1], eff_trim[1]);
        ch_out_ra <= apply_trim(ch_in[2], eff_trim[2]);
      end
    end
  end

  // Slow update enable for the amplitude results
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      update_tick_q <= 1'b0;
    end else if (tick_cnt_q == CW'(UPDATE_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      update_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + CW'(1);
      update_tick_q <= 1'b0;
    end
  end

  for (genvar g = 0; g < NC; g++) begin : g_amp
    gtacl_tone_avg #(
      .SHIFT(AVG_SHIFT)
    ) u_avg (
      .mclk(mclk),
      .rst(rst),
      .enable(acloff_enable),
      .sample_valid(tone_valid),
      .sample(tone_in[g]),
      .update_tick(update_tick_q),
      .code_q(tone_amplitude_code[g])
    );
  end
endmodule : gtacl_regs

/* verif/gtacl_regs_asserts.sv */
// Concurrent checks on the register port and the trim path
`timescale 1ns/1ps
module gtacl_regs_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_word,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_word,
  input wire logic [1:0] gain_setting,
  input wire logic ch_valid,
  input wire logic ch_out_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd = cmd_valid && !cmd_write;
  wire [7:0] ra = rsp_word[31:24];
  wire trim_rsp = rsp_valid && ra inside {8'h21, 8'h22, 8'h23};
  a_read_answer: assert property (rd |=> rsp_valid) else $error("read not answered");
  a_no_spurious: assert property (!rd |=> !rsp_valid) else $error("answer without read");
  a_rsp_hold: assert property (!rd |=> $stable(rsp_word)) else $error("answer word moved");
  a_rsp_addr: assert property (rd |=> ra == $past(cmd_word[31:24])) else $error("bad addr");
  a_trim_resv: assert property (trim_rsp |-> rsp_word[22:12] == 11'h000) else $error("trim resv");
  a_amp_resv: assert property (rsp_valid && ra inside {8'h31, 8'h32, 8'h33}
    |-> rsp_word[23:16] == 8'h00) else $error("amplitude reserved bits set");
  a_gain3_unity: assert property (trim_rsp && !rsp_word[23] && $past(gain_setting) == 2'h3
    |-> rsp_word[11:0] == 12'h000) else $error("gain 3 factory trim not zero");
  a_write_back: assert property (cmd_valid && cmd_write && cmd_word[31:23] == {8'h21, 1'b1}
    ##1 rd && cmd_word[31:24] == 8'h21
    |=> rsp_word[23:0] == {12'h800, $past(cmd_word[11:0], 2)}) else $error("user trim lost");
  a_ch_latency: assert property (ch_valid |=> ch_out_valid) else $error("no trimmed sample");
  c_read: cover property (rd ##1 rsp_valid);
  c_write_read: cover property (cmd_valid && cmd_write ##1 rd);
  c_channel: cover property (ch_valid ##1 ch_out_valid);
endmodule : gtacl_regs_asserts

/* verif/gtacl_host.sv */
// Host model issuing register commands on the falling edge
`timescale 1ns/1ps
module gtacl_host (
  input wire logic mclk,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_word,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [31:0] cmd_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_word = 32'h0000_0000;
  end
  // Caller enters at a falling edge; commands may follow back to back
  task automatic xfer(input logic wr, input logic [31:0] w, output logic [32:0] rsp);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_word = wr ? w & 32'hFF80_0FFF : w;
    @(negedge mclk);
    rsp = {rsp_valid, rsp_word};
  endtask : xfer
  task automatic idle;
    cmd_valid = 1'b0;
    cmd_word = ~cmd_word; // Released lines must not look valid
  endtask : idle
endmodule : gtacl_host

/* verif/tb.sv */
// Self-checking bench for the gain trim and amplitude register bank
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] gain_setting = 2'h0;
  logic ch_valid = 1'b0;
  logic acloff_enable = 1'b0;
  logic tone_valid = 1'b0;
  logic [35:0] ft [3];
  logic signed [23:0] chd [3];
  wire signed [23:0] cho [3];
  logic signed [15:0] tone [3];
  logic [11:0] ut [3];
  logic [15:0] amp [3];
  logic cmd_valid, cmd_write, rsp_valid, ch_out_valid;
  logic [31:0] cmd_word, rsp_word;
  logic [32:0] r;
  integer seed = 71732;
  integer mismatches = 0;
  integer checks = 0;
  always #10 mclk = ~mclk;
  gtacl_regs #(.UPDATE_CYCLES(16), .AVG_SHIFT(4)) uut (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .gain_setting(gain_setting),
    .factory_trim_la(ft[0]), .factory_trim_ll(ft[1]), .factory_trim_ra(ft[2]),
    .ch_valid(ch_valid), .ch_data_la(chd[0]), .ch_data_ll(chd[1]), .ch_data_ra(chd[2]),
    .ch_out_valid(ch_out_valid), .ch_out_la(cho[0]), .ch_out_ll(cho[1]), .ch_out_ra(cho[2]),
    .acloff_enable(acloff_enable), .tone_valid(tone_valid), .tone_sample_la(tone[0]),
    .tone_sample_ll(tone[1]), .tone_sample_ra(tone[2]));
  gtacl_host host (.mclk(mclk), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word));
  function automatic logic [31:0] f_trim(int i, logic s, logic [1:0] g);
    logic [11:0] t;
    t = s ? ut[i] : (g == 2'h3 ? 12'h000 : ft[i][12*g +: 12]);
    return {8'h21 + 8'(i), s, 11'h000, t};
  endfunction : f_trim
  function automatic logic [23:0] f_ch(logic signed [23:0] d, logic [11:0] t);
    logic signed [47:0] p;
    p = d * $signed(t);
    return d + p[40:17];
  endfunction : f_ch
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      ft[i] = 36'({$random(seed), $random(seed)});
      chd[i] = 24'h000000;
      tone[i] = 16'h0000;
    end
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    // Select clear first, so a written user trim must stay hidden
    for (int s = 0; s < 2; s++) begin
      for (int i = 2; i >= 0; i--) begin
        ut[i] = (i == 0) ? 12'h7FF : (i == 1) ? 12'h800 : 12'($random(seed));
        host.xfer(1'b1, {8'h21 + 8'(i), s[0], 11'h7FF, ut[i]}, r);
      end
      for (int g = 0; g < 4; g++) begin
        gain_setting = 2'(g);
        for (int i = 0; i < 3; i++) begin
          host.xfer(1'b0, {8'h21 + 8'(i), 24'h000000}, r);
          chk(r[31:0], f_trim(i, s[0], 2'(g)));
          chk({31'h0, r[32]}, 32'h1);
        end
      end
    end
    foreach (amp[i]) begin
      host.xfer(1'b1, {8'h1F + 8'(i * 8'h12), 24'hFFFFFF}, r);
      host.xfer(1'b0, {8'h1F + 8'(i * 8'h12), 24'h000000}, r);
      chk(r[31:0], {8'h1F + 8'(i * 8'h12), 24'h000000});
    end
    host.idle();
    for (int n = 0; n < 8; n++) begin
      foreach (chd[i]) chd[i] = 24'($random(seed));
      ch_valid = 1'b1;
      @(negedge mclk);
      chk({31'h0, ch_out_valid}, 32'h1);
      foreach (cho[i]) chk({8'h00, cho[i]}, {8'h00, f_ch(chd[i], ut[i])});
    end
    ch_valid = 1'b0;
    acloff_enable = 1'b1;
    tone_valid = 1'b1;
    foreach (amp[i]) amp[i] = {4'h0, 12'($random(seed))};
    for (int n = 0; n < 640; n++) begin
      foreach (tone[i]) tone[i] = n[0] ? 16'h0000 - amp[i] : amp[i];
      @(negedge mclk);
    end
    for (int e = 1; e >= 0; e--) begin
      acloff_enable = e[0];
      repeat (40) @(negedge mclk);
      foreach (amp[i]) begin
        host.xfer(1'b0, {8'h31 + 8'(i), 24'h000000}, r);
        chk(r[31:0], {8'h31 + 8'(i), 8'h00, e[0] ? amp[i] : 16'h0000});
      end
      host.idle();
    end
    wrap_up();
  end
endmodule : tb
bind gtacl_regs gtacl_regs_asserts chk_i (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
  .gain_setting(gain_setting), .ch_valid(ch_valid), .ch_out_valid(ch_out_valid));
